// [inc/ddrrb_pkg.sv]
// Constants and types shared by both ends of the read-burst link.
// Assumes one clock shared by controller and device model.
package ddrrb_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BANK_W = 3;
  localparam int NBANK = 8;
  localparam int CNT_W = 6;
  // Command encodings
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_ACT = 3'h1;
  localparam logic [2:0] CMD_RD = 3'h2;
  localparam logic [2:0] CMD_WR = 3'h3;
  localparam logic [2:0] CMD_PRE = 3'h4;
  localparam logic [2:0] CMD_MRS = 3'h5;
  // Mode register zero field positions
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_CL_LSB = 3;
  localparam int MR0_RTP_LSB = 9;
  localparam int MR0_AL_LSB = 12;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_PER_CMD = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [2:0] RTP_SIX_CODE = 3'h1;
  localparam logic [CNT_W-1:0] RTP_SIX = 6'h06;
  localparam logic [CNT_W-1:0] RTP_DEFAULT = 6'h05;
  localparam logic [ADDR_W-1:0] MR0_RESET = 16'h0240;
  // Address bits
  localparam int AUTO_PRE_BIT = 10;
  localparam int CHOP_BIT = 12;
  localparam logic [3:0] BEATS_EIGHT = 4'h8;
  localparam logic [3:0] BEATS_FOUR = 4'h4;
  // Controller bank timing and lowest write latency, in clocks
  localparam logic [CNT_W-1:0] RAS_MIN = 6'h1c;
  localparam logic [CNT_W-1:0] RP_MIN = 6'h0b;
  localparam logic [CNT_W-1:0] RC_MIN = 6'h27;
  localparam logic [CNT_W-1:0] CWL_LOWEST = 6'h09;
  typedef enum logic [1:0] {DDRRB_IDLE, DDRRB_WAIT, DDRRB_BURST}
    ddrrb_rd_type;
endpackage : ddrrb_pkg

// [inc/ddrrb_if.sv]
// Command and data link between controller and device.
// Assumes both ends share clock; device drives the read data.
interface ddrrb_if;
  import ddrrb_pkg::*;
  logic [2:0] cmd;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  modport ctrl (output cmd, output bank, output addr,
                input rdata, input rvalid);
  modport dev (input cmd, input bank, input addr,
               output rdata, output rvalid);
endinterface : ddrrb_if

// [rtl/ddrrb_dev.sv]
// Device end: mode register zero, read bursts, auto precharge.
// Assumes controller keeps bank spacing; data comes from a counter.
module ddrrb_dev
  import ddrrb_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic resetn, // Sync reset, low
  input wire logic clk_en, // Freezes state when low
  ddrrb_if.dev link, // Command link
  output logic [NBANK-1:0] bank_open, // Open banks
  output logic [ADDR_W-1:0] mode_zero, // Mode register zero
  output logic [CNT_W-1:0] rtp_clocks // Read-to-precharge delay
);
  // ------------------------------------------------------------
  // Mode register
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] mr0_r;
  logic [CNT_W-1:0] rl;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mr0_r <= MR0_RESET;
    end else if (clk_en && link.cmd == CMD_MRS) begin
      mr0_r <= link.addr;
    end
  end
  assign mode_zero = mr0_r;
  assign rtp_clocks = (mr0_r[MR0_RTP_LSB+:3] == RTP_SIX_CODE) ?
                      RTP_SIX : RTP_DEFAULT;
  assign rl = CNT_W'(mr0_r[MR0_AL_LSB+:4]) +
              CNT_W'(mr0_r[MR0_CL_LSB+:5]);

  function automatic logic [3:0] beats(input logic [1:0] bl,
                                       input logic chop);
    if (bl == BL_FIXED4) begin
      return BEATS_FOUR;
    end else if (bl == BL_PER_CMD) begin
      return chop ? BEATS_EIGHT : BEATS_FOUR;
    end
    return BEATS_EIGHT;
  endfunction : beats

  // ------------------------------------------------------------
  // Read burst sequencer
  // ------------------------------------------------------------
  ddrrb_rd_type st_r;
  logic [CNT_W-1:0] wait_r;
  logic [3:0] left_r;
  logic [DATA_W-1:0] data_r;
  logic rvalid_r;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_r <= DDRRB_IDLE;
      wait_r <= '0;
      left_r <= '0;
      data_r <= '0;
      rvalid_r <= 1'b0;
    end else if (clk_en) begin
      rvalid_r <= 1'b0;
      case (st_r)
        DDRRB_IDLE: begin
          if (link.cmd == CMD_RD) begin
            left_r <= beats(mr0_r[MR0_BL_LSB+:2], link.addr[CHOP_BIT]);
            data_r <= link.addr;
            // First beat is sampled read_latency edges after the command
            if (rl <= 6'h02) begin
              st_r <= DDRRB_BURST;
            end else begin
              wait_r <= rl - 6'h03;
              st_r <= DDRRB_WAIT;
            end
          end
        end
        DDRRB_WAIT: begin
          if (wait_r == '0) begin
            st_r <= DDRRB_BURST;
          end else begin
            wait_r <= wait_r - 6'h01;
          end
        end
        DDRRB_BURST: begin
          rvalid_r <= 1'b1;
          data_r <= data_r + 16'h0001;
          left_r <= left_r - 4'h1;
          if (left_r == 4'h1) begin
            st_r <= DDRRB_IDLE;
          end
        end
        default: begin
          st_r <= DDRRB_IDLE;
        end
      endcase
    end
  end
  assign link.rvalid = rvalid_r;
  assign link.rdata = data_r;

  // ------------------------------------------------------------
  // Bank state and auto precharge
  // ------------------------------------------------------------
  logic [NBANK-1:0] open_r;
  logic ap_pend_r;
  logic [BANK_W-1:0] ap_bank_r;
  logic [CNT_W-1:0] ap_cnt_r;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      open_r <= '0;
      ap_pend_r <= 1'b0;
      ap_bank_r <= '0;
      ap_cnt_r <= '0;
    end else if (clk_en) begin
      if (link.cmd == CMD_ACT) begin
        open_r[link.bank] <= 1'b1;
      end else if (link.cmd == CMD_PRE) begin
        open_r[link.bank] <= 1'b0;
      end
      if (link.cmd == CMD_RD && link.addr[AUTO_PRE_BIT]) begin
        ap_pend_r <= 1'b1;
        ap_bank_r <= link.bank;
        ap_cnt_r <= CNT_W'(mr0_r[MR0_AL_LSB+:4]) + rtp_clocks;
      end else if (ap_pend_r) begin
        if (ap_cnt_r <= 6'h01) begin
          ap_pend_r <= 1'b0;
          open_r[ap_bank_r] <= 1'b0;
        end else begin
          ap_cnt_r <= ap_cnt_r - 6'h01;
        end
      end
    end
  end
  assign bank_open = open_r;
endmodule : ddrrb_dev

// [rtl/ddrrb_ctrl.sv]
// Controller end: issues commands and keeps bank spacing.
// Assumes user holds a request until accepted.
module ddrrb_ctrl
  import ddrrb_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic resetn, // Sync reset, low
  input wire logic clk_en, // Freezes state when low
  ddrrb_if.ctrl link, // Command link
  input wire logic req_valid, // Command request
  input wire logic [2:0] req_cmd, // Command code
  input wire logic [BANK_W-1:0] req_bank, // Bank
  input wire logic [ADDR_W-1:0] req_addr, // Address
  input wire logic two_clk_wpre, // Two-clock write preamble
  input wire logic [CNT_W-1:0] cwl_req, // Wanted write latency
  output logic req_ready, // Request accepted
  output logic [CNT_W-1:0] cwl_used, // Programmed write latency
  output logic [DATA_W-1:0] rd_data, // Read beat
  output logic rd_valid // Read beat valid
);
  // ------------------------------------------------------------
  // Per-bank timers
  // ------------------------------------------------------------
  logic [CNT_W-1:0] ras_r [NBANK];
  logic [CNT_W-1:0] rc_r [NBANK];
  logic [CNT_W-1:0] rp_r [NBANK];
  logic [CNT_W-1:0] rtp_r [NBANK];
  logic [ADDR_W-1:0] mr0_r;
  logic [CNT_W-1:0] rtp_cl;
  logic [CNT_W-1:0] cwl_r;
  logic ok;
  assign rtp_cl = (mr0_r[MR0_RTP_LSB+:3] == RTP_SIX_CODE) ?
                  RTP_SIX : RTP_DEFAULT;

  function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
    return (v == '0) ? v : v - 6'h01;
  endfunction : dec

  always_comb begin
    ok = 1'b1;
    case (req_cmd)
      CMD_PRE: begin
        ok = rtp_r[req_bank] == '0 && ras_r[req_bank] == '0;
      end
      CMD_ACT: begin
        ok = rp_r[req_bank] == '0 && rc_r[req_bank] == '0;
      end
      default: begin
        ok = 1'b1;
      end
    endcase
  end
  assign req_ready = ok;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < NBANK; i++) begin
        ras_r[i] <= '0;
        rc_r[i] <= '0;
        rp_r[i] <= '0;
        rtp_r[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NBANK; i++) begin
        ras_r[i] <= dec(ras_r[i]);
        rc_r[i] <= dec(rc_r[i]);
        rp_r[i] <= dec(rp_r[i]);
        rtp_r[i] <= dec(rtp_r[i]);
      end
      if (req_valid && ok) begin
        case (req_cmd)
          CMD_ACT: begin
            ras_r[req_bank] <= RAS_MIN - 6'h01;
            rc_r[req_bank] <= RC_MIN - 6'h01;
          end
          CMD_RD: begin
            rtp_r[req_bank] <= CNT_W'(mr0_r[MR0_AL_LSB+:4]) + rtp_cl
                               - 6'h01;
            if (req_addr[AUTO_PRE_BIT]) begin
              rp_r[req_bank] <= CNT_W'(mr0_r[MR0_AL_LSB+:4]) + rtp_cl
                                + RP_MIN - 6'h01;
            end
          end
          CMD_PRE: begin
            rp_r[req_bank] <= RP_MIN - 6'h01;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Shadow of mode register, write latency, command outputs
  // ------------------------------------------------------------
  logic [2:0] cmd_r;
  logic [BANK_W-1:0] bank_r;
  logic [ADDR_W-1:0] addr_r;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mr0_r <= MR0_RESET;
      cwl_r <= CWL_LOWEST;
      cmd_r <= CMD_NOP;
      bank_r <= '0;
      addr_r <= '0;
    end else if (clk_en) begin
      cmd_r <= (req_valid && ok) ? req_cmd : CMD_NOP;
      bank_r <= req_bank;
      addr_r <= req_addr;
      if (req_valid && req_cmd == CMD_MRS) begin
        mr0_r <= req_addr;
      end
      if (two_clk_wpre && cwl_req <= CWL_LOWEST) begin
        cwl_r <= CWL_LOWEST + 6'h01;
      end else begin
        cwl_r <= (cwl_req < CWL_LOWEST) ? CWL_LOWEST : cwl_req;
      end
    end
  end
  assign link.cmd = cmd_r;
  assign link.bank = bank_r;
  assign link.addr = addr_r;
  assign cwl_used = cwl_r;
  assign rd_data = link.rdata;
  assign rd_valid = link.rvalid;
endmodule : ddrrb_ctrl

// [bench/ddrrb_sva.sv]
// Assertions on the link between controller and device.
// Assumes one clock and reset; sees link signals only.
module ddrrb_sva
  import ddrrb_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic resetn, // Sync reset, low
  input wire logic [2:0] cmd, // Command
  input wire logic [BANK_W-1:0] bank, // Bank
  input wire logic [ADDR_W-1:0] addr, // Address
  input wire logic [DATA_W-1:0] rdata, // Read beat
  input wire logic rvalid // Beat valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Link history
  // ----
  logic [ADDR_W-1:0] mode_r;
  logic [7:0] rd_n_r, act_n_r, pre_n_r, rtp;
  logic [BANK_W-1:0] rd_b_r, act_b_r, pre_b_r;
  logic go, pre, act;
  // Read from idle, latency eight
  assign go = cmd == CMD_RD && !rvalid && mode_r[15:12] == 4'h0
    && mode_r[7:3] == 5'h08;
  assign pre = cmd == CMD_PRE;
  assign act = cmd == CMD_ACT;
  assign rtp = {4'h0, mode_r[15:12]}
    + (mode_r[11:9] == RTP_SIX_CODE ? 8'h06 : 8'h05);
  function automatic logic [7:0] age(logic [7:0] n, logic hit);
    return hit ? 8'h01 : n + {7'h0, n != 8'hff};
  endfunction : age
  always_ff @(posedge clock) begin
    mode_r <= !resetn ? MR0_RESET : cmd == CMD_MRS ? addr : mode_r;
  end
  always_ff @(posedge clock) begin
    rd_n_r <= !resetn ? 8'hff : age(rd_n_r, cmd == CMD_RD);
    act_n_r <= !resetn ? 8'hff : age(act_n_r, act);
    pre_n_r <= !resetn ? 8'hff : age(pre_n_r, pre);
  end
  always_ff @(posedge clock) begin
    if (cmd == CMD_RD) rd_b_r <= bank;
    if (act) act_b_r <= bank;
    if (pre) pre_b_r <= bank;
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_four; rvalid [*4] ##1 !rvalid; endsequence
  sequence s_eight; rvalid [*8] ##1 !rvalid; endsequence
  chk_read_latency:
    assert property (go |-> ##1 !rvalid [*7] ##1 rvalid)
    else $error("read data off latency");
  chk_fixed_four:
    assert property (go && mode_r[1:0] == BL_FIXED4 |-> ##8 s_four)
    else $error("fixed chop not four beats");
  chk_otf_eight:
    assert property (go && mode_r[1:0] == BL_PER_CMD && addr[CHOP_BIT]
      |-> ##8 s_eight) else $error("per command burst not eight");
  chk_otf_four:
    assert property (go && mode_r[1:0] == BL_PER_CMD && !addr[CHOP_BIT]
      |-> ##8 s_four) else $error("per command chop not four");
  chk_beat_step:
    assert property (rvalid && $past(rvalid) |-> rdata == $past(rdata) + 1'b1)
    else $error("beat data not consecutive");
  chk_read_to_pre:
    assert property (pre && bank == rd_b_r |-> rd_n_r >= rtp)
    else $error("precharge too soon after read");
  chk_act_to_pre:
    assert property (pre && bank == act_b_r |-> act_n_r >= {2'h0, RAS_MIN})
    else $error("precharge too soon after activate");
  chk_pre_to_act:
    assert property (act && bank == pre_b_r |-> pre_n_r >= {2'h0, RP_MIN})
    else $error("activate too soon after precharge");
  chk_row_cycle:
    assert property (act && bank == act_b_r |-> act_n_r >= {2'h0, RC_MIN})
    else $error("activate inside row cycle");
endmodule : ddrrb_sva

// [bench/test_ddr4_read_burst_precharge_timing.sv]
// Bench: controller and device on one link, beats against a model.
// Assumes 100 MHz clock; reset low for the first two cycles.
module test_ddr4_read_burst_precharge_timing
  import ddrrb_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, resetn = 1'b0, req_valid = 1'b0, clk_en = 1'b1;
  logic two_clk_wpre = 1'b0, req_ready, rd_valid, ok;
  logic [2:0] req_cmd = CMD_NOP;
  logic [1:0] bl = BL_FIXED8;
  logic [BANK_W-1:0] req_bank = '0;
  logic [ADDR_W-1:0] req_addr = '0, mode_zero;
  logic [CNT_W-1:0] cwl_req = '0, cwl_used, rtp_clocks;
  logic [DATA_W-1:0] rd_data;
  logic [NBANK-1:0] bank_open;
  int n_mismatch = 0, n_tests = 0;
  int exp_q[$];
  ddrrb_if lk();
  ddrrb_ctrl u_ddrrb_ctrl (.clock, .resetn, .clk_en, .link(lk), .req_valid,
    .req_cmd, .req_bank, .req_addr, .two_clk_wpre, .cwl_req, .req_ready,
    .cwl_used, .rd_data, .rd_valid);
  ddrrb_dev u_ddrrb_dev (.clock, .resetn, .clk_en, .link(lk), .bank_open,
    .mode_zero, .rtp_clocks);
  ddrrb_sva u_ddrrb_sva (.clock, .resetn, .cmd(lk.cmd), .bank(lk.bank),
    .addr(lk.addr), .rdata(lk.rdata), .rvalid(lk.rvalid));
  always #5 clock = ~clock;
  // ----
  // Tasks
  // ----
  task automatic check(string what, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask : check
  task automatic issue(logic [2:0] c, int b, logic [15:0] a);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= BANK_W'(b);
    req_addr <= a;
    do begin
      @(negedge clock) ok = req_ready;
      n++;
      @(posedge clock);
    end while (!ok && n < 300);
    if (!ok) check("req_ready", 16'h1, 16'h0);
    for (int i = 1; c == CMD_RD && i <= ((bl == BL_FIXED4
      || (bl == BL_PER_CMD && !a[CHOP_BIT])) ? 4 : 8); i++)
      exp_q.push_back(int'(a) + i);
    req_valid <= 1'b0;
    @(posedge clock);
  endtask : issue
  task automatic drain();
    for (int n = 0; n < 100 && exp_q.size() > 0; n++) @(posedge clock);
    check("beats left", 16'h0, 16'(exp_q.size()));
    repeat (2) @(posedge clock);
  endtask : drain
  task automatic mrs(logic [1:0] b, logic [2:0] rtp);
    logic [15:0] v;
    v = {MR0_RESET[15:12], rtp, MR0_RESET[8:2], b};
    bl = b;
    issue(CMD_MRS, 0, v);
    repeat (2) @(posedge clock);
    check("mode_zero", v, mode_zero);
  endtask : mrs
  function automatic logic [15:0] col(logic chop, logic ap);
    return (16'($urandom) & 16'hebff) | {3'h0, chop, 1'b0, ap, 10'h0};
  endfunction : col
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // ----
  // Model compare and tests
  // ----
  always @(negedge clock) begin
    if (resetn && rd_valid !== 1'b0) begin
      if (exp_q.size() == 0) check("rd_valid", 16'h0, 16'(rd_valid));
      else check("rd_data", 16'(exp_q.pop_front()), rd_data);
    end
  end
  // Run needs about 300 cycles; allow 10k
  initial begin
    #100us;
    n_mismatch++;
    conclude();
  end
  initial begin
    logic [1:0] modes [3];
    logic [CNT_W-1:0] e;
    int b;
    modes = '{BL_FIXED8, BL_PER_CMD, BL_FIXED4};
    void'($urandom(6496));
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    check("mode_zero", MR0_RESET, mode_zero);
    check("rtp_clocks", 16'(RTP_SIX), 16'(rtp_clocks));
    check("bank_open", 16'h0, 16'(bank_open));
    @(posedge clock);
    $display("reset values done");
    foreach (modes[k]) begin
      mrs(modes[k], RTP_SIX_CODE);
      b = $urandom_range(NBANK - 1);
      issue(CMD_ACT, b, 16'($urandom));
      for (int c = 0; c < 2; c++) begin
        issue(CMD_RD, b, col(c[0], 1'b0));
        drain();
        check("bank_open", 16'h1, 16'(bank_open[b]));
      end
      issue(CMD_PRE, b, 16'h0);
      $display("burst mode %0d done", modes[k]);
    end
    mrs(BL_PER_CMD, 3'h0);
    check("rtp_clocks", 16'(RTP_DEFAULT), 16'(rtp_clocks));
    issue(CMD_ACT, b, 16'h0);
    repeat (30) @(posedge clock);
    issue(CMD_RD, b, col(1'b0, 1'b0));
    issue(CMD_PRE, b, 16'h0);
    drain();
    mrs(BL_PER_CMD, RTP_SIX_CODE);
    issue(CMD_ACT, 5, 16'h0);
    issue(CMD_RD, 5, col(1'b1, 1'b1));
    drain();
    check("bank_open", 16'h0, 16'(bank_open[5]));
    $display("precharge tests done");
    for (int k = 0; k < 8; k++) begin
      cwl_req <= k < 6 ? CNT_W'(8 + k / 2) : CNT_W'($urandom_range(20, 9));
      two_clk_wpre <= k[0];
      repeat (2) @(posedge clock);
      e = cwl_req > CWL_LOWEST ? cwl_req : CWL_LOWEST;
      if (two_clk_wpre && cwl_req <= CWL_LOWEST) e = CWL_LOWEST + 6'h1;
      check("cwl_used", 16'(e), 16'(cwl_used));
    end
    $display("write latency done");
    conclude();
  end
endmodule : test_ddr4_read_burst_precharge_timing
